/* File: ch3_oc.sv */
// Channel 3 output compare reference generator with register port
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The implementer's own choice: strobed register access.
module ch3_oc #(
    parameter int CNT_W = 16
) (
    input  wire logic                           MCLK,
    input  wire logic                           RST_B,
    input  wire logic [ch3_oc_pkg::ADDR_W-1:0]  ADDR,
    input  wire logic [ch3_oc_pkg::DATA_W-1:0]  WDATA,
    input  wire logic                           WR,
    input  wire logic                           RD,
    output logic      [ch3_oc_pkg::DATA_W-1:0]  RDATA,
    input  wire logic [CNT_W-1:0]               TIMER_COUNTER_VALUE,
    input  wire logic                           CNT_DOWN,
    input  wire logic                           CNT_STEP,
    input  wire logic                           UPDATE_EVENT,
    input  wire logic                           TRIGGER_EVENT,
    input  wire logic                           OVF_UDF_EVENT,
    input  wire logic                           FILTERED_EXTERNAL_TRIGGER,
    output logic                                CHANNEL_REFERENCE,
    output logic                                CHANNEL_OUT
);
    import ch3_oc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic pwm_level(input logic             mode2,
                                       input logic             down,
                                       input logic [CNT_W-1:0] cnt,
                                       input logic [CNT_W-1:0] up_cmp,
                                       input logic [CNT_W-1:0] dn_cmp);
        logic act;
        act = down ? !(cnt > dn_cmp) : (cnt < up_cmp);
        return mode2 ? !act : act;
    endfunction : pwm_level

    function automatic logic is_pwm12(input logic [3:0] m);
        return (m == OM_PWM1) || (m == OM_PWM2);
    endfunction : is_pwm12

    initial begin
        if (CNT_W < 1 || CNT_W > 32) begin
            $error("ch3_oc: CNT_W must be 1..32");
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [3:0]        mode_r;
    logic [3:0]        mode_nxt;
    logic              clr_en_r;
    logic              clr_en_nxt;
    logic              pre_en_r;
    logic              pre_en_nxt;
    logic              ima_en_r;
    logic              ima_en_nxt;
    logic              pol_r;
    logic              pol_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              wr_ocfg;
    logic              wr_pol;
    logic              wr_ccr;
    logic              wr_acr;
    logic [CNT_W-1:0]  ccr_pre;
    logic [CNT_W-1:0]  ccr_act;
    logic [CNT_W-1:0]  acr_pre;
    logic [CNT_W-1:0]  acr_act;
    imm_state_t        imm_r;
    imm_state_t        imm_nxt;
    logic              oref_r;
    logic              oref_nxt;
    logic              out_r;
    logic              out_nxt;

    assign wr_ocfg = WR && (ADDR == OCFG_OFS);
    assign wr_pol  = WR && (ADDR == POL_OFS);
    assign wr_ccr  = WR && (ADDR == CCR_OFS);
    assign wr_acr  = WR && (ADDR == ACR_OFS);

    always_comb begin
        mode_nxt   = mode_r;
        clr_en_nxt = clr_en_r;
        pre_en_nxt = pre_en_r;
        ima_en_nxt = ima_en_r;
        pol_nxt    = pol_r;
        rdata_nxt  = '0;
        if (wr_ocfg) begin
            mode_nxt   = {WDATA[MODE_HI_BIT], WDATA[MODE_LO_MSB:0]};
            clr_en_nxt = WDATA[CLR_EN_BIT];
            pre_en_nxt = WDATA[PRE_EN_BIT];
            ima_en_nxt = WDATA[IMA_EN_BIT];
        end
        if (wr_pol) begin
            pol_nxt = WDATA[POL_BIT];
        end
        if (RD) begin
            case (ADDR)
                OCFG_OFS: begin
                    rdata_nxt[MODE_HI_BIT]     = mode_r[3];
                    rdata_nxt[MODE_LO_MSB:0]   = mode_r[2:0];
                    rdata_nxt[CLR_EN_BIT]      = clr_en_r;
                    rdata_nxt[PRE_EN_BIT]      = pre_en_r;
                    rdata_nxt[IMA_EN_BIT]      = ima_en_r;
                end
                POL_OFS: begin
                    rdata_nxt[POL_BIT] = pol_r;
                end
                CCR_OFS: begin
                    rdata_nxt[CNT_W-1:0] = ccr_pre;
                end
                ACR_OFS: begin
                    rdata_nxt[CNT_W-1:0] = acr_pre;
                end
                STAT_OFS: begin
                    rdata_nxt[STAT_REF_BIT] = oref_r;
                    rdata_nxt[STAT_IMM_BIT] = (imm_r == IMM_HOLD);
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_r   <= {OCFG_RST[MODE_HI_BIT], OCFG_RST[MODE_LO_MSB:0]};
            clr_en_r <= OCFG_RST[CLR_EN_BIT];
            pre_en_r <= OCFG_RST[PRE_EN_BIT];
            ima_en_r <= OCFG_RST[IMA_EN_BIT];
            pol_r    <= POL_RST;
            rdata_r  <= '0;
        end else begin
            mode_r   <= mode_nxt;
            clr_en_r <= clr_en_nxt;
            pre_en_r <= pre_en_nxt;
            ima_en_r <= ima_en_nxt;
            pol_r    <= pol_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    // ------------------------------------------------------------
    // Compare values
    // ------------------------------------------------------------
    cmp_shadow #(.W(CNT_W)) u_ccr (
        .clk         (MCLK),
        .rst_b       (RST_B),
        .wr_en       (wr_ccr),
        .wr_val      (WDATA[CNT_W-1:0]),
        .preload_en  (pre_en_r),
        .update      (UPDATE_EVENT),
        .preload_val (ccr_pre),
        .active_val  (ccr_act)
    );

    cmp_shadow #(.W(CNT_W)) u_acr (
        .clk         (MCLK),
        .rst_b       (RST_B),
        .wr_en       (wr_acr),
        .wr_val      (WDATA[CNT_W-1:0]),
        .preload_en  (pre_en_r),
        .update      (UPDATE_EVENT),
        .preload_val (acr_pre),
        .active_val  (acr_act)
    );

    // ------------------------------------------------------------
    // Reference generation
    // ------------------------------------------------------------
    logic match;
    logic imm_trig;
    logic imm_on;
    logic clr_now;

    assign match    = CNT_STEP && (TIMER_COUNTER_VALUE == ccr_act);
    assign imm_trig = ima_en_r && is_pwm12(mode_r) && TRIGGER_EVENT;
    assign imm_on   = imm_trig || (imm_r == IMM_HOLD);
    assign clr_now  = clr_en_r && FILTERED_EXTERNAL_TRIGGER;

    always_comb begin
        imm_nxt = imm_r;
        case (imm_r)
            IMM_IDLE: begin
                if (imm_trig) begin
                    imm_nxt = IMM_HOLD;
                end
            end
            IMM_HOLD: begin
                if (!is_pwm12(mode_r) || (OVF_UDF_EVENT && !imm_trig)) begin
                    imm_nxt = IMM_IDLE;
                end
            end
            default: begin
                imm_nxt = IMM_IDLE;
            end
        endcase

        oref_nxt = oref_r;
        case (mode_r)
            OM_CLR: begin
                if (match) oref_nxt = 1'b0;
            end
            OM_SET: begin
                if (match) oref_nxt = 1'b1;
            end
            OM_TOG: begin
                if (match) oref_nxt = !oref_r;
            end
            OM_FRC0: oref_nxt = 1'b0;
            OM_FRC1: oref_nxt = 1'b1;
            OM_PWM1, OM_PWM2: begin
                if (imm_on) begin
                    oref_nxt = mode_r[0];
                end else begin
                    oref_nxt = pwm_level(mode_r[0], CNT_DOWN, TIMER_COUNTER_VALUE,
                                         ccr_act, ccr_act);
                end
            end
            OM_APWM1, OM_APWM2: begin
                oref_nxt = pwm_level(mode_r[0], CNT_DOWN, TIMER_COUNTER_VALUE,
                                     ccr_act, acr_act);
            end
            default: oref_nxt = oref_r;
        endcase
        if (clr_now) begin
            oref_nxt = 1'b0;
        end
        out_nxt = oref_nxt ^ pol_r;
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            imm_r  <= IMM_IDLE;
            oref_r <= 1'b0;
            out_r  <= 1'b0;
        end else begin
            imm_r  <= imm_nxt;
            oref_r <= oref_nxt;
            out_r  <= out_nxt;
        end
    end

    assign CHANNEL_REFERENCE = oref_r;
    assign CHANNEL_OUT       = out_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    sequence trig_s;
        ima_en_r && is_pwm12(mode_r) && TRIGGER_EVENT && !clr_now;
    endsequence

    sequence hold_ovf_s;
        imm_r == IMM_HOLD && OVF_UDF_EVENT && !TRIGGER_EVENT;
    endsequence

    imm_force_a: assert property (
        trig_s |=> CHANNEL_REFERENCE == $past(mode_r[0]) && imm_r == IMM_HOLD)
        else $error("Trigger did not force matched level");
    imm_end_a: assert property (
        hold_ovf_s |=> imm_r == IMM_IDLE)
        else $error("Forced level outlived overflow");
    imm_ignore_a: assert property (
        imm_r == IMM_IDLE && !is_pwm12(mode_r) |=> imm_r == IMM_IDLE)
        else $error("Immediate active outside PWM 1/2");
    clear_force_a: assert property (
        clr_now |=> !CHANNEL_REFERENCE)
        else $error("Reference not cleared by trigger");
    hold_mode_a: assert property (
        (mode_r == OM_HOLD || (mode_r[3] && mode_r[2:1] != 2'h3)) && !clr_now
        && !wr_ocfg |=> $stable(CHANNEL_REFERENCE))
        else $error("Hold mode changed reference");
    toggle_a: assert property (
        mode_r == OM_TOG && match && !clr_now |=> CHANNEL_REFERENCE != $past(oref_r))
        else $error("Toggle on match missing");
    force_lvl_a: assert property (
        mode_r == OM_FRC1 && !clr_now |=> CHANNEL_REFERENCE)
        else $error("Force active not high");
    pwm1_up_a: assert property (
        mode_r == OM_PWM1 && !imm_on && !CNT_DOWN && !clr_now
        && TIMER_COUNTER_VALUE < ccr_act |=> CHANNEL_REFERENCE)
        else $error("PWM1 up level wrong");
    pwm2_dn_a: assert property (
        mode_r == OM_PWM2 && !imm_on && CNT_DOWN && !clr_now
        && TIMER_COUNTER_VALUE > ccr_act |=> CHANNEL_REFERENCE)
        else $error("PWM2 down level wrong");
    apwm_dn_a: assert property (
        mode_r == OM_APWM1 && CNT_DOWN && !clr_now
        && TIMER_COUNTER_VALUE > acr_act |=> !CHANNEL_REFERENCE)
        else $error("Asym PWM1 down level wrong");
    pol_out_a: assert property (
        ##1 CHANNEL_OUT == (CHANNEL_REFERENCE ^ $past(pol_r)))
        else $error("Polarity not applied");

endmodule : ch3_oc

/* File: ch3_oc_pkg.sv */
// Constants and types shared by the channel 3 output compare block
package ch3_oc_pkg;

    // ------------------------------------------------------------
    // Register bus and map
    // ------------------------------------------------------------
    localparam int              ADDR_W      = 8;
    localparam int              DATA_W      = 32;
    localparam logic [7:0]      OCFG_OFS    = 8'h4C;
    localparam logic [7:0]      POL_OFS     = 8'h54;
    localparam logic [7:0]      CCR_OFS     = 8'h8C;
    localparam logic [7:0]      ACR_OFS     = 8'h90;
    localparam logic [7:0]      STAT_OFS    = 8'h94;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int              MODE_HI_BIT = 8;
    localparam int              MODE_LO_MSB = 2;
    localparam int              CLR_EN_BIT  = 3;
    localparam int              PRE_EN_BIT  = 4;
    localparam int              IMA_EN_BIT  = 5;
    localparam int              POL_BIT     = 6;
    localparam int              STAT_REF_BIT = 0;
    localparam int              STAT_IMM_BIT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0]     OCFG_RST    = 32'h0000_0000;
    localparam logic [31:0]     CMP_RST     = 32'h0000_0000;
    localparam logic            POL_RST     = 1'h0;

    // ------------------------------------------------------------
    // Output mode codes and single-pulse state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OM_HOLD  = 4'h0,
        OM_CLR   = 4'h1,
        OM_SET   = 4'h2,
        OM_TOG   = 4'h3,
        OM_FRC0  = 4'h4,
        OM_FRC1  = 4'h5,
        OM_PWM1  = 4'h6,
        OM_PWM2  = 4'h7,
        OM_APWM1 = 4'hE,
        OM_APWM2 = 4'hF
    } out_mode_t;

    typedef enum logic {
        IMM_IDLE = 1'h0,
        IMM_HOLD = 1'h1
    } imm_state_t;

endpackage : ch3_oc_pkg

/* File: cmp_shadow.sv */
// Compare value with preload register and active shadow
module cmp_shadow #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_val,
    input  wire logic         preload_en,
    input  wire logic         update,
    output logic      [W-1:0] preload_val,
    output logic      [W-1:0] active_val
);
    import ch3_oc_pkg::*;

    logic [W-1:0] pre_r;
    logic [W-1:0] pre_nxt;
    logic [W-1:0] act_r;
    logic [W-1:0] act_nxt;

    initial begin
        if (W < 1 || W > 32) begin
            $error("cmp_shadow: W must be 1..32");
        end
    end

    always_comb begin
        pre_nxt = wr_en ? wr_val : pre_r;
        act_nxt = act_r;
        if (wr_en && !preload_en) begin
            act_nxt = wr_val;
        end else if (update && preload_en) begin
            act_nxt = pre_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= CMP_RST[W-1:0];
            act_r <= CMP_RST[W-1:0];
        end else begin
            pre_r <= pre_nxt;
            act_r <= act_nxt;
        end
    end

    assign preload_val = pre_r;
    assign active_val  = act_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    direct_write_a: assert property (
        wr_en && !preload_en |=> active_val == $past(wr_val))
        else $error("Direct write not used at once");
    shadow_hold_a: assert property (
        preload_en && !update |=> $stable(active_val))
        else $error("Shadow changed without update");
    update_copy_a: assert property (
        preload_en && update |=> active_val == $past(preload_val))
        else $error("Update did not copy preload");

endmodule : cmp_shadow

/* File: testbench.sv */
// Self-checking testbench for the channel 3 output compare block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ch3_oc_pkg::*;

    logic              mclk;
    logic              rst_b;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              wr;
    logic              rd;
    logic [15:0]       cnt;
    logic              cnt_down;
    logic              cnt_step;
    logic              upd_ev;
    logic              trig_ev;
    logic              ovf_ev;
    logic              ext_trig;
    logic              chan_ref;
    logic              chan_out;
    logic              pol;
    int                n_mismatch;
    int                num_checks;
    logic [7:0]        ofs_tab [6];
    logic [21:0]       pwm_tab [18];

    ch3_oc #(.CNT_W(16)) ch3_oc_inst (
        .MCLK                      (mclk),
        .RST_B                     (rst_b),
        .ADDR                      (addr),
        .WDATA                     (wdata),
        .WR                        (wr),
        .RD                        (rd),
        .RDATA                     (rdata),
        .TIMER_COUNTER_VALUE       (cnt),
        .CNT_DOWN                  (cnt_down),
        .CNT_STEP                  (cnt_step),
        .UPDATE_EVENT              (upd_ev),
        .TRIGGER_EVENT             (trig_ev),
        .OVF_UDF_EVENT             (ovf_ev),
        .FILTERED_EXTERNAL_TRIGGER (ext_trig),
        .CHANNEL_REFERENCE         (chan_ref),
        .CHANNEL_OUT               (chan_out)
    );

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Access and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_reg

    task automatic set_mode(input logic [3:0] m, input logic [2:0] en);
        wr_reg(OCFG_OFS, {23'h0, m[3], 2'h0, en, m[2:0]});
    endtask : set_mode

    // Drive one cycle of timer inputs, then let the result land
    task automatic tick(input logic [15:0] c, input logic dn, input logic st,
                        input logic up, input logic tr, input logic ov, input logic et);
        @(posedge mclk);
        cnt      <= c;
        cnt_down <= dn;
        cnt_step <= st;
        upd_ev   <= up;
        trig_ev  <= tr;
        ovf_ev   <= ov;
        ext_trig <= et;
        @(posedge mclk);
        cnt_step <= 1'b0;
        upd_ev   <= 1'b0;
        trig_ev  <= 1'b0;
        ovf_ev   <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : tick

    task automatic ref_is(input logic exp);
        chk({31'h0, chan_ref}, {31'h0, exp});
        chk({31'h0, chan_out}, {31'h0, exp ^ pol});
    endtask : ref_is

    task automatic tally_and_finish;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {addr, wdata, wr, rd, cnt, cnt_down, cnt_step} = '0;
        {upd_ev, trig_ev, ovf_ev, ext_trig, pol} = '0;
        n_mismatch = 0;
        num_checks = 0;
        ofs_tab = '{OCFG_OFS, POL_OFS, CCR_OFS, ACR_OFS, STAT_OFS, 8'h10};
        // Mode, count, down, expected level with compare 5 and asym 8
        pwm_tab = '{{4'h6, 16'h0003, 2'b01}, {4'h6, 16'h0005, 2'b00},
                    {4'h6, 16'h0006, 2'b10}, {4'h6, 16'h0005, 2'b11},
                    {4'h6, 16'h0004, 2'b11}, {4'h7, 16'h0003, 2'b00},
                    {4'h7, 16'h0005, 2'b01}, {4'h7, 16'h0006, 2'b11},
                    {4'h7, 16'h0005, 2'b10}, {4'hE, 16'h0004, 2'b01},
                    {4'hE, 16'h0006, 2'b00}, {4'hE, 16'h0009, 2'b10},
                    {4'hE, 16'h0007, 2'b11}, {4'hE, 16'h0008, 2'b11},
                    {4'hF, 16'h0004, 2'b00}, {4'hF, 16'h0006, 2'b01},
                    {4'hF, 16'h0009, 2'b11}, {4'hF, 16'h0007, 2'b10}};
        rst_b = 1'b0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (ofs_tab[i]) rd_reg(ofs_tab[i], 32'h0);
        wr_reg(OCFG_OFS, 32'hFFFF_FFFF);
        rd_reg(OCFG_OFS, 32'h0000_013F);
        wr_reg(POL_OFS, 32'hFFFF_FFFF);
        rd_reg(POL_OFS, 32'h0000_0040);
        wr_reg(8'h10, 32'hFFFF_FFFF);
        rd_reg(8'h10, 32'h0);
        wr_reg(POL_OFS, 32'h0);
        set_mode(4'h0, 3'h0);
        wr_reg(CCR_OFS, 32'h5);
        rd_reg(CCR_OFS, 32'h5);
        wr_reg(ACR_OFS, 32'h8);
        // Forced levels, both polarities
        set_mode(4'h5, 3'h0);
        tick(16'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b1);
        set_mode(4'h4, 3'h0);
        wr_reg(POL_OFS, 32'h40);
        pol = 1'b1;
        tick(16'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b0);
        set_mode(4'h5, 3'h0);
        tick(16'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b1);
        wr_reg(POL_OFS, 32'h0);
        pol = 1'b0;
        // Match actions, then hold codes
        set_mode(4'h1, 3'h0);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b1);
        tick(16'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b0);
        set_mode(4'h2, 3'h0);
        tick(16'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b1);
        set_mode(4'h3, 3'h0);
        tick(16'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b0);
        tick(16'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b1);
        tick(16'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b0);
        tick(16'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b1);
        for (int m = 0; m < 14; m++) begin
            if (m == 0 || m > 7) begin
                set_mode(m[3:0], 3'h0);
                tick(16'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
                ref_is(1'b1);
            end
        end
        // Symmetric and asymmetric PWM table
        foreach (pwm_tab[i]) begin
            set_mode(pwm_tab[i][21:18], 3'h0);
            tick(pwm_tab[i][17:2], pwm_tab[i][1], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            ref_is(pwm_tab[i][0]);
        end
        // Preload shadow versus immediate write
        set_mode(4'h6, 3'h2);
        wr_reg(CCR_OFS, 32'hA);
        rd_reg(CCR_OFS, 32'hA);
        tick(16'h7, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b0);
        tick(16'h7, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        ref_is(1'b1);
        set_mode(4'h6, 3'h0);
        wr_reg(CCR_OFS, 32'h6);
        tick(16'h7, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b0);
        // Clear by external trigger
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        ref_is(1'b1);
        set_mode(4'h6, 3'h1);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        ref_is(1'b0);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b1);
        // Single-pulse immediate active
        set_mode(4'h6, 3'h4);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        ref_is(1'b0);
        rd_reg(STAT_OFS, 32'h2);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ref_is(1'b0);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        ref_is(1'b1);
        set_mode(4'h7, 3'h4);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        ref_is(1'b1);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        ref_is(1'b0);
        set_mode(4'h5, 3'h0);
        tick(16'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        set_mode(4'h0, 3'h4);
        tick(16'h3, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        ref_is(1'b1);
        rd_reg(STAT_OFS, 32'h1);
        tally_and_finish();
    end

endmodule : testbench
